// ### hdl/mfc_flow_control.sv
// ethernet mac flow control: pause transmit, pause receive, backpressure
//
// Overview of operation
// R1: sent pause frames carry configured pause time
// R2: software spaces writes for synchronised pause time
// R3: auto resend pause at selected timer threshold
// R4: pause timing counted in 512-bit slot times
// R5: software keeps threshold below pause time
// R6: unicast detect adds station address match
// R7: decode enable halts transmitter for pause time
// R8: full duplex flow enable permits pause frames
// R9: half duplex flow enable permits backpressure
// R10: send bit stays set until frame done
// R11: software writes only after send bit clears
// R12: backpressure jams each newly received frame
// R13: full duplex forces backpressure off
// R14: pause frame needs type 8808, opcode 0001
// R15: received pause counts down per slot time
// R16: new pause frame reloads running pause timer
`timescale 1ns/1ps
`include "mfc_defs.svh"

module mfc_flow_control #(
	parameter int ADDR_W       = 8,
	parameter int SLOT_NIBBLES = `MFC_SLOT_NIBBLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// register port
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [31:0]            regRdata,
	// mac mode and timing
	input  wire logic              fullDuplex,
	input  wire logic              nibbleTick,
	input  wire logic              rxCongested,
	// received frame information
	input  wire logic              rxFrameStart,
	input  wire logic              rxCtrlValid,
	input  wire logic [47:0]       rxDestAddr,
	input  wire logic [15:0]       rxTypeLen,
	input  wire logic [15:0]       rxOpcode,
	input  wire logic [15:0]       rxPauseTime,
	input  wire logic [47:0]       stationAddr,
	// pause frame transmit request
	output logic                   pauseTxReq,
	output logic [15:0]            pauseTxTime,
	input  wire logic              pauseTxDone,
	// transmitter control
	output logic                   txPaused,
	output logic                   backpressureActive,
	output logic                   jamRequest
);

	// threshold code to remaining slot count at which to resend
	function automatic mfc_pkg::mfc_quanta_t thresholdOffset(input logic [1:0] code);
		case (code)
			2'h0:    thresholdOffset = `MFC_THR_CODE0;
			2'h1:    thresholdOffset = `MFC_THR_CODE1;
			2'h2:    thresholdOffset = `MFC_THR_CODE2;
			default: thresholdOffset = `MFC_THR_CODE3;
		endcase
	endfunction

	// address decode shared by reads and writes
	function automatic logic hitReg(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
		hitReg = (addr == ADDR_W'(offset));
	endfunction

	// configuration fields
	mfc_pkg::mfc_quanta_t pauseQuantaValue;
	logic [1:0]           pauseRetxThreshold;
	logic                 unicastPauseDetect;
	logic                 rxPauseDecodeEnable;
	logic                 txFlowControlEnable;
	logic                 backpressureBit;

	// sequencer and timers
	mfc_pkg::mfc_txstate_e txState;
	mfc_pkg::mfc_txstate_e next_txState;
	mfc_pkg::mfc_quanta_t  retxRemain;
	mfc_pkg::mfc_quanta_t  next_retxRemain;
	mfc_pkg::mfc_quanta_t  rxRemain;
	mfc_pkg::mfc_quanta_t  next_rxRemain;
	logic                  slotTick;

	// decoded strobes
	logic cfgWrite;
	logic swSend;
	logic autoSend;
	logic pauseMatch;
	logic addrMatch;
	logic pauseSendBusy;
	logic bpEnable;

	// slot time enable from nibble times
	// R4: slot time base
	mfc_slot_timer #(
		.SLOT_NIBBLES(SLOT_NIBBLES)
	) slotTimer (
		.clk       (clk),
		.reset_n   (reset_n),
		.nibbleTick(nibbleTick),
		.slotTick  (slotTick)
	);

	// write decode
	assign cfgWrite = regWrite && hitReg(regAddr, `MFC_REG_CFG);

	// software pause request, only with flow control enabled in the same write
	// R8: send gated by enable
	// R10: software sets send bit
	assign swSend = cfgWrite && fullDuplex && regWdata[`MFC_CFG_SEND] && regWdata[`MFC_CFG_TXFC];

	assign pauseSendBusy = (txState == mfc_pkg::TX_SEND);

	// automatic resend once the remaining time falls to the threshold offset
	// R3: threshold resend
	assign autoSend = (txState == mfc_pkg::TX_WAIT) && rxCongested && txFlowControlEnable &&
		(retxRemain == thresholdOffset(pauseRetxThreshold));

	// destination check: reserved multicast, or own address when enabled
	// R6: unicast pause detect
	assign addrMatch = (rxDestAddr == `MFC_PAUSE_MCAST) ||
		(unicastPauseDetect && (rxDestAddr == stationAddr));

	// full pause frame recognition
	// R14: type and opcode
	// R7: decode enable
	assign pauseMatch = rxCtrlValid && fullDuplex && rxPauseDecodeEnable && addrMatch &&
		(rxTypeLen == `MFC_PAUSE_TYPE) && (rxOpcode == `MFC_PAUSE_OPCODE);

	// backpressure only in half duplex with both bits set
	// R9: half duplex enable
	// R13: full duplex disables
	assign bpEnable = !fullDuplex && txFlowControlEnable && backpressureBit;

	// configuration fields written by software
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pauseQuantaValue    <= 16'(`MFC_CFG_RESET >> `MFC_CFG_PT_LSB);
			pauseRetxThreshold  <= 2'h0;
			unicastPauseDetect  <= 1'b0;
			rxPauseDecodeEnable <= 1'b0;
			txFlowControlEnable <= 1'b0;
		end else if (cfgWrite) begin
			pauseQuantaValue    <= regWdata[`MFC_CFG_PT_MSB:`MFC_CFG_PT_LSB];
			pauseRetxThreshold  <= regWdata[`MFC_CFG_PLT_MSB:`MFC_CFG_PLT_LSB];
			unicastPauseDetect  <= regWdata[`MFC_CFG_UPD];
			rxPauseDecodeEnable <= regWdata[`MFC_CFG_RXDEC];
			txFlowControlEnable <= regWdata[`MFC_CFG_TXFC];
		end
	end

	// backpressure bit: plain read/write in half duplex, forced off in full duplex
	// R13: auto clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			backpressureBit <= 1'b0;
		end else if (fullDuplex) begin
			backpressureBit <= 1'b0;
		end else if (cfgWrite) begin
			backpressureBit <= regWdata[`MFC_CFG_SEND];
		end
	end

	// pause transmit sequencer
	always_comb begin
		next_txState = txState;
		case (txState)
			mfc_pkg::TX_IDLE: begin
				if (swSend) begin
					next_txState = mfc_pkg::TX_SEND;
				end
			end
			mfc_pkg::TX_SEND: begin
				// R10: hold until done, set wins
				if (!fullDuplex) begin
					next_txState = mfc_pkg::TX_IDLE;
				end else if (pauseTxDone && !swSend) begin
					next_txState = (pauseTxTime != '0) ? mfc_pkg::TX_WAIT : mfc_pkg::TX_IDLE;
				end
			end
			mfc_pkg::TX_WAIT: begin
				// R3: resend or expire
				if (!fullDuplex) begin
					next_txState = mfc_pkg::TX_IDLE;
				end else if (swSend || autoSend) begin
					next_txState = mfc_pkg::TX_SEND;
				end else if (retxRemain == '0) begin
					next_txState = mfc_pkg::TX_IDLE;
				end
			end
			default: begin
				next_txState = mfc_pkg::TX_IDLE;
			end
		endcase
	end

	// sequencer state register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			txState <= mfc_pkg::TX_IDLE;
		end else begin
			txState <= next_txState;
		end
	end

	// request level to the transmitter follows the send state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pauseTxReq <= 1'b0;
		end else begin
			pauseTxReq <= (next_txState == mfc_pkg::TX_SEND);
		end
	end

	// pause time field captured as each frame is started
	// R1: pause time field
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pauseTxTime <= '0;
		end else if (next_txState == mfc_pkg::TX_SEND && txState != mfc_pkg::TX_SEND) begin
			pauseTxTime <= cfgWrite ? regWdata[`MFC_CFG_PT_MSB:`MFC_CFG_PT_LSB] : pauseQuantaValue;
		end
	end

	// resend timer: loaded with the sent pause time, counts slots
	always_comb begin
		next_retxRemain = retxRemain;
		if (txState == mfc_pkg::TX_SEND && next_txState == mfc_pkg::TX_WAIT) begin
			next_retxRemain = pauseTxTime;
		end else if (txState == mfc_pkg::TX_WAIT && slotTick && retxRemain != '0) begin
			// R4: one slot per count
			next_retxRemain = retxRemain - 16'h0001;
		end
	end

	// resend timer register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			retxRemain <= '0;
		end else begin
			retxRemain <= next_retxRemain;
		end
	end

	// receive pause timer
	always_comb begin
		next_rxRemain = rxRemain;
		if (pauseMatch) begin
			// R16: reload on new frame
			next_rxRemain = rxPauseTime;
		end else if (slotTick && rxRemain != '0) begin
			// R15: count down per slot
			next_rxRemain = rxRemain - 16'h0001;
		end
	end

	// receive pause timer register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rxRemain <= '0;
		end else begin
			rxRemain <= next_rxRemain;
		end
	end

	// transmitter halted while the receive timer runs
	// R15: resume at zero
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			txPaused <= 1'b0;
		end else begin
			txPaused <= (next_rxRemain != '0);
		end
	end

	// backpressure level output
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			backpressureActive <= 1'b0;
		end else begin
			backpressureActive <= bpEnable;
		end
	end

	// jam request pulse for each new frame under backpressure
	// R12: jam new frames
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			jamRequest <= 1'b0;
		end else begin
			jamRequest <= rxFrameStart && bpEnable;
		end
	end

	// register read data, one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regRdata <= '0;
		end else if (regRead) begin
			regRdata <= '0;
			if (hitReg(regAddr, `MFC_REG_CFG)) begin
				regRdata[`MFC_CFG_PT_MSB:`MFC_CFG_PT_LSB]   <= pauseQuantaValue;
				regRdata[`MFC_CFG_PLT_MSB:`MFC_CFG_PLT_LSB] <= pauseRetxThreshold;
				regRdata[`MFC_CFG_UPD]                      <= unicastPauseDetect;
				regRdata[`MFC_CFG_RXDEC]                    <= rxPauseDecodeEnable;
				regRdata[`MFC_CFG_TXFC]                     <= txFlowControlEnable;
				// R10: busy reads back
				regRdata[`MFC_CFG_SEND]                     <= fullDuplex ? pauseSendBusy : backpressureBit;
			end else if (hitReg(regAddr, `MFC_REG_STAT)) begin
				regRdata[`MFC_STAT_PAUSED]                   <= txPaused;
				regRdata[`MFC_STAT_BUSY]                     <= pauseSendBusy;
				regRdata[`MFC_STAT_BP]                       <= backpressureActive;
				regRdata[`MFC_STAT_RX_LSB +: 16]             <= rxRemain;
			end
		end else begin
			regRdata <= '0;
		end
	end

endmodule

// ### hdl/mfc_slot_timer.sv
// slot time enable generator counting mii nibble times
`timescale 1ns/1ps
`include "mfc_defs.svh"

module mfc_slot_timer #(
	parameter int SLOT_NIBBLES = `MFC_SLOT_NIBBLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// nibble time enable in, slot time enable out
	input  wire logic nibbleTick,
	output logic      slotTick
);

	localparam int CW = $clog2(SLOT_NIBBLES);
	localparam logic [CW-1:0] LAST = CW'(SLOT_NIBBLES - 1);

	logic [CW-1:0] nibbleCount;

	// count nibbles, wrap at one slot
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			nibbleCount <= '0;
		end else if (nibbleTick) begin
			nibbleCount <= (nibbleCount == LAST) ? '0 : nibbleCount + 1'b1;
		end
	end

	// one-cycle pulse at the end of each slot
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			slotTick <= 1'b0;
		end else begin
			slotTick <= nibbleTick && (nibbleCount == LAST);
		end
	end

endmodule

// ### shared/mfc_defs.svh
// offsets, field positions, reset values and timing counts of the flow-control block
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH

// register offsets (byte addresses)
`define MFC_REG_CFG        8'h18
`define MFC_REG_STAT       8'h1c

// configuration register fields
`define MFC_CFG_PT_MSB     31
`define MFC_CFG_PT_LSB     16
`define MFC_CFG_PLT_MSB    5
`define MFC_CFG_PLT_LSB    4
`define MFC_CFG_UPD        3
`define MFC_CFG_RXDEC      2
`define MFC_CFG_TXFC       1
`define MFC_CFG_SEND       0
`define MFC_CFG_RESET      32'h0000_0000

// status register fields
`define MFC_STAT_PAUSED    0
`define MFC_STAT_BUSY      1
`define MFC_STAT_BP        2
`define MFC_STAT_RX_LSB    16

// slot time: 512 bits carried four bits per mii nibble
`define MFC_SLOT_BITS      512
`define MFC_NIBBLE_BITS    4
`define MFC_SLOT_NIBBLES   (`MFC_SLOT_BITS / `MFC_NIBBLE_BITS)

// retransmission threshold offsets in slot times
`define MFC_THR_CODE0      16'h0004
`define MFC_THR_CODE1      16'h001c
`define MFC_THR_CODE2      16'h0090
`define MFC_THR_CODE3      16'h0100

// pause frame recognition
`define MFC_PAUSE_TYPE     16'h8808
`define MFC_PAUSE_OPCODE   16'h0001
`define MFC_PAUSE_MCAST    48'h0180_c200_0001

`endif

// ### shared/mfc_pkg.sv
// types shared by the flow-control block
package mfc_pkg;

	// pause frame transmit sequencer
	typedef enum logic [1:0] {
		TX_IDLE,
		TX_SEND,
		TX_WAIT
	} mfc_txstate_e;

	// pause time in slot times
	typedef logic [15:0] mfc_quanta_t;

endpackage

// ### testbench/mfc_fc_props.sv
// port assertions for the flow-control block
`timescale 1ns/1ps
`include "mfc_defs.svh"

module mfc_fc_props #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              reset_n,
	// register and mode inputs
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [31:0]       regWdata,
	input wire logic              regWrite,
	input wire logic              fullDuplex,
	// receive side
	input wire logic              rxFrameStart,
	input wire logic              rxCtrlValid,
	input wire logic [15:0]       rxTypeLen,
	input wire logic [15:0]       rxOpcode,
	// watched outputs
	input wire logic              pauseTxReq,
	input wire logic [15:0]       pauseTxTime,
	input wire logic              pauseTxDone,
	input wire logic              txPaused,
	input wire logic              backpressureActive,
	input wire logic              jamRequest
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// software send request on the config word
	wire logic sendWr = regWrite && regAddr == `MFC_REG_CFG && regWdata[1:0] == 2'h3;

	// send starts with the written pause time
	AST_SEND: assert property (sendWr && fullDuplex |=> pauseTxReq && pauseTxTime == $past(regWdata[31:16]))
		else $error("pause send not started with written time");
	AST_HOLD: assert property (pauseTxReq && $past(pauseTxReq) |-> $stable(pauseTxTime))
		else $error("pause time moved during send");
	AST_DONE: assert property (pauseTxReq && pauseTxDone && !sendWr |=> !pauseTxReq)
		else $error("send request kept after done");
	AST_HDX: assert property (!fullDuplex && !$past(fullDuplex) |-> !pauseTxReq)
		else $error("pause send in half duplex");
	AST_FDXBP: assert property (fullDuplex |=> !backpressureActive)
		else $error("backpressure in full duplex");
	AST_JAMSRC: assert property (jamRequest |-> $past(rxFrameStart) && !$past(fullDuplex))
		else $error("jam without frame start");
	AST_JAM: assert property (rxFrameStart && backpressureActive && !fullDuplex |=> jamRequest)
		else $error("frame start not jammed");
	AST_TYPE: assert property (rxCtrlValid && rxTypeLen != `MFC_PAUSE_TYPE && !txPaused |=> !txPaused)
		else $error("pause on wrong type");
	AST_OPC: assert property (rxCtrlValid && rxOpcode != `MFC_PAUSE_OPCODE && !txPaused |=> !txPaused)
		else $error("pause on wrong opcode");

	// main scenarios reached
	COV_SEND: cover property (pauseTxReq && pauseTxDone);
	COV_PAUSE: cover property ($fell(txPaused));
	COV_JAM: cover property (jamRequest);
endmodule

bind mfc_flow_control mfc_fc_props #(.ADDR_W(ADDR_W)) u_props (
	.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
	.fullDuplex(fullDuplex), .rxFrameStart(rxFrameStart), .rxCtrlValid(rxCtrlValid), .rxTypeLen(rxTypeLen),
	.rxOpcode(rxOpcode), .pauseTxReq(pauseTxReq), .pauseTxTime(pauseTxTime), .pauseTxDone(pauseTxDone),
	.txPaused(txPaused), .backpressureActive(backpressureActive), .jamRequest(jamRequest)
);

// ### testbench/mfc_phy_model.sv
// far side model: mii nibble timing and pause frame transmitter
`timescale 1ns/1ps

module mfc_phy_model (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// pause frame handshake
	input  wire logic       pauseTxReq,
	input  wire logic [3:0] latency,
	output logic            pauseTxDone,
	// mii nibble timing
	output logic            nibbleTick
);
	logic [3:0] count;

	// nibble time base
	// one nibble every second clock
	always_ff @(posedge clk) begin
		nibbleTick <= reset_n && !nibbleTick;
	end

	// frame completion pulse
	// frame finishes latency plus one cycles after request
	always_ff @(posedge clk) begin
		if (!reset_n || !pauseTxReq || pauseTxDone) begin
			count <= 4'h0;
			pauseTxDone <= 1'h0;
		end else begin
			count <= count + 4'h1;
			pauseTxDone <= (count == latency);
		end
	end
endmodule

// ### testbench/testbench.sv
// self-checking bench for the flow-control block
`timescale 1ns/1ps
`include "mfc_defs.svh"

module testbench;
	// bench signals
	logic        clk, reset_n, regWrite, regRead, fullDuplex, rxCongested, rxFrameStart, rxCtrlValid;
	logic [7:0]  regAddr;
	logic [31:0] regWdata, regRdata, rdv, cw;
	logic [47:0] rxDestAddr, stationAddr;
	logic [15:0] rxTypeLen, rxOpcode, rxPauseTime, pauseTxTime, pt;
	logic [15:0] offs [4];
	logic [3:0]  latency;
	logic        nibbleTick, pauseTxReq, pauseTxDone, txPaused, backpressureActive, jamRequest;
	int          n_mismatch, samples_checked, cycles, n;

	mfc_flow_control #(.SLOT_NIBBLES(4)) dut (
		.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
		.regRead(regRead), .regRdata(regRdata), .fullDuplex(fullDuplex), .nibbleTick(nibbleTick),
		.rxCongested(rxCongested), .rxFrameStart(rxFrameStart), .rxCtrlValid(rxCtrlValid),
		.rxDestAddr(rxDestAddr), .rxTypeLen(rxTypeLen), .rxOpcode(rxOpcode), .rxPauseTime(rxPauseTime),
		.stationAddr(stationAddr), .pauseTxReq(pauseTxReq), .pauseTxTime(pauseTxTime),
		.pauseTxDone(pauseTxDone), .txPaused(txPaused), .backpressureActive(backpressureActive),
		.jamRequest(jamRequest)
	);
	mfc_phy_model u_phy (
		.clk(clk), .reset_n(reset_n), .pauseTxReq(pauseTxReq), .latency(latency),
		.pauseTxDone(pauseTxDone), .nibbleTick(nibbleTick)
	);

	// print counts and verdict, end run
	task give_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// register write and read
	task wr(input logic [7:0] a, input logic [31:0] d);
		repeat (3) @(posedge clk);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'h1;
		@(posedge clk);
		regWrite <= 1'h0;
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge clk);
		regRead <= 1'h0;
		#1 d = regRdata;
	endtask

	// cycles until send request (0) or pause (1) reaches lvl
	task wait_for(input int sel, input logic lvl, output int k);
		for (k = 1; k < 400; k++) begin
			@(posedge clk);
			#1;
			if ((sel == 0 ? pauseTxReq : txPaused) === lvl)
				break;
		end
	endtask

	// one received control frame
	task rx(input logic [47:0] da, input logic [15:0] t, input logic [15:0] o, input logic [15:0] q);
		@(posedge clk);
		rxCtrlValid <= 1'h1;
		rxDestAddr <= da;
		rxTypeLen <= t;
		rxOpcode <= o;
		rxPauseTime <= q;
		@(posedge clk);
		rxCtrlValid <= 1'h0;
		#1;
	endtask

	// frame start pulse
	task frame_start;
		@(posedge clk);
		rxFrameStart <= 1'h1;
		@(posedge clk);
		rxFrameStart <= 1'h0;
		#1;
	endtask

	// clock
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			give_verdict;
		end
	end

	// main sequence
	initial begin
		{reset_n, regWrite, regRead, rxCongested, rxFrameStart, rxCtrlValid} = 6'h00;
		{regAddr, regWdata, rxDestAddr, rxTypeLen, rxOpcode, rxPauseTime} = '0;
		fullDuplex = 1'h1;
		stationAddr = 48'h02_0000_0000_5a;
		latency = 4'h3;
		offs = '{`MFC_THR_CODE0, `MFC_THR_CODE1, `MFC_THR_CODE2, `MFC_THR_CODE3};
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		rd(`MFC_REG_CFG, rdv);
		chk(rdv, `MFC_CFG_RESET);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, rdv);
		chk(rdv, 32'h0);
		// send, readback and automatic resend per threshold code
		for (int c = 0; c < 4; c++) begin
			@(posedge clk);
			rxCongested <= 1'h1;
			latency <= 4'h3 + 4'(c * 4);
			pt = offs[c] + 16'h4;
			cw = {pt, 10'h000, 2'(c), 4'h3};
			wr(`MFC_REG_CFG, cw);
			chk(32'(pauseTxReq), 32'h1);
			chk(32'(pauseTxTime), 32'(pt));
			rd(`MFC_REG_CFG, rdv);
			chk(rdv, cw);
			wait_for(0, 1'h0, n);
			wait_for(0, 1'h1, n);
			chk(32'(n >= 20 && n <= 36), 32'h1);
			chk(32'(pauseTxTime), 32'(pt));
			@(posedge clk) rxCongested <= 1'h0;
			wait_for(0, 1'h0, n);
			rd(`MFC_REG_CFG, rdv);
			chk(32'(rdv[0]), 32'h0);
		end
		wr(`MFC_REG_CFG, 32'h0010_0001);
		chk(32'(pauseTxReq), 32'h0);
		// pause reception: rejects, accept, unicast, reload, disable
		wr(`MFC_REG_CFG, 32'h4);
		for (int i = 0; i < 3; i++) begin
			rx(i == 2 ? stationAddr : `MFC_PAUSE_MCAST, i == 0 ? 16'h8800 : `MFC_PAUSE_TYPE,
				i == 1 ? 16'h0002 : `MFC_PAUSE_OPCODE, 16'h2);
			chk(32'(txPaused), 32'h0);
		end
		rx(`MFC_PAUSE_MCAST, `MFC_PAUSE_TYPE, `MFC_PAUSE_OPCODE, 16'h2);
		chk(32'(txPaused), 32'h1);
		wait_for(1, 1'h0, n);
		chk(32'(n >= 8 && n <= 18), 32'h1);
		wr(`MFC_REG_CFG, 32'hc);
		rx(stationAddr, `MFC_PAUSE_TYPE, `MFC_PAUSE_OPCODE, 16'h3);
		chk(32'(txPaused), 32'h1);
		rd(`MFC_REG_STAT, rdv);
		chk(32'(rdv[2:0]), 32'h1);
		repeat (10) @(posedge clk);
		rx(`MFC_PAUSE_MCAST, `MFC_PAUSE_TYPE, `MFC_PAUSE_OPCODE, 16'h3);
		wait_for(1, 1'h0, n);
		chk(32'(n >= 16 && n <= 26), 32'h1);
		wr(`MFC_REG_CFG, 32'h0);
		rx(`MFC_PAUSE_MCAST, `MFC_PAUSE_TYPE, `MFC_PAUSE_OPCODE, 16'h2);
		chk(32'(txPaused), 32'h0);
		// half duplex backpressure and jam
		@(posedge clk) fullDuplex <= 1'h0;
		wr(`MFC_REG_CFG, 32'h3);
		@(posedge clk);
		#1 chk(32'(backpressureActive), 32'h1);
		chk(32'(pauseTxReq), 32'h0);
		frame_start;
		chk(32'(jamRequest), 32'h1);
		wr(`MFC_REG_CFG, 32'h1);
		@(posedge clk);
		#1 chk(32'(backpressureActive), 32'h0);
		frame_start;
		chk(32'(jamRequest), 32'h0);
		wr(`MFC_REG_CFG, 32'h3);
		@(posedge clk) fullDuplex <= 1'h1;
		@(posedge clk);
		#1 chk(32'(backpressureActive), 32'h0);
		rd(`MFC_REG_CFG, rdv);
		chk(32'(rdv[0]), 32'h0);
		give_verdict;
	end
endmodule
